// ===== qdu_pkg.sv
// package for the quad dac update and clear control block
// Function
// - synchronous channels take input register on 32nd falling serial clock edge
// - asynchronous channels: command 0000 frame writes input register only, dac register untouched
// - load strobe falling edge copies input to dac for pin-controlled channels
// - command 0010 writes input register then updates all dac registers
// - override bit 0 follows pin; bit 1 updates at frame end as pin low
// - command 0110 loads override register from frame bits 3 to 0
// - override register resets to all zeros
// - override frame bits 3..0 select channels d,c,b,a; other bits ignored
// - clear select 00 gives 0000, 01 8000, 10 FFFF, 11 no clear
// - clear code frame: command 0101, selector in bits 1 and 0
// - frame is 32 bits: 4 spare, command, address, 16 data, 4 spare
// - frame select rising before 32nd edge discards the frame
// - clear strobe falling loads clear code everywhere and aborts the frame
// - command 0101 loads clear selector from frame bits 1 and 0
package qdu_pkg;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W = 6;
   localparam int CMD_MSB = 27;
   localparam int CMD_LSB = 24;
   localparam int ADDR_MSB = 23;
   localparam int ADDR_LSB = 20;
   localparam int DATA_MSB = 19;
   localparam int DATA_LSB = 4;
   localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
   localparam logic [3:0] CMD_WRITE_UPDATE_ONE = 4'h3;
   localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
   localparam logic [3:0] CMD_LOAD_CLEAR_SEL = 4'h5;
   localparam logic [3:0] CMD_LOAD_OVERRIDE = 4'h6;
   localparam logic [3:0] ADDR_ALL = 4'hF;
   localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
   localparam logic [1:0] CLR_SEL_MID = 2'h1;
   localparam logic [1:0] CLR_SEL_FULL = 2'h2;
   localparam logic [1:0] CLR_SEL_NONE = 2'h3;
   localparam logic [15:0] CLR_CODE_ZERO = 16'h0000;
   localparam logic [15:0] CLR_CODE_MID = 16'h8000;
   localparam logic [15:0] CLR_CODE_FULL = 16'hFFFF;
   localparam logic [1:0] CLR_SEL_RESET = 2'h0;
   localparam logic [3:0] OVERRIDE_RESET = 4'h0;
   localparam logic [15:0] DAC_RESET = 16'h0000;
   typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_WAIT_END} qdu_frame_state_t;
endpackage

// ===== qdu_sync.sv
// two flip-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module qdu_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic async_i,
   output logic level_o,
   output logic fall_o,
   output logic rise_o
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;
   logic last_reg;
   logic last_next;

   always_comb begin
      meta_next = async_i;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
         last_reg <= RESET_VAL;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level_o = sync_reg;
   assign fall_o = last_reg & ~sync_reg;
   assign rise_o = ~last_reg & sync_reg;
endmodule

// ===== qdu_top.sv
// quad dac update and clear control: serial frame decode, update and clear logic
`timescale 1ns/1ps
module qdu_top
   import qdu_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int CODE_W = 16
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic sclk_i,
   input wire logic frame_sel_n_i,
   input wire logic sdin_i,
   input wire logic load_strobe_n_i,
   input wire logic clear_strobe_n_i,
   output logic [CHANNELS*CODE_W-1:0] input_regs_o,
   output logic [CHANNELS*CODE_W-1:0] dac_regs_o,
   output logic [CHANNELS-1:0] override_o,
   output logic [1:0] clear_sel_o,
   output logic frame_done_o
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic sclk_lvl;
   logic sclk_fall;
   logic fs_lvl;
   logic fs_fall;
   logic fs_rise;
   logic din_lvl;
   logic ld_lvl;
   logic ld_fall;
   logic clr_fall;

   qdu_sync #(.RESET_VAL(1'b1)) u_sclk (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .async_i(sclk_i),
      .level_o(sclk_lvl), .fall_o(sclk_fall), .rise_o());
   qdu_sync #(.RESET_VAL(1'b1)) u_fs (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .async_i(frame_sel_n_i),
      .level_o(fs_lvl), .fall_o(fs_fall), .rise_o(fs_rise));
   qdu_sync #(.RESET_VAL(1'b0)) u_din (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .async_i(sdin_i),
      .level_o(din_lvl), .fall_o(), .rise_o());
   qdu_sync #(.RESET_VAL(1'b1)) u_ld (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .async_i(load_strobe_n_i),
      .level_o(ld_lvl), .fall_o(ld_fall), .rise_o());
   qdu_sync #(.RESET_VAL(1'b1)) u_clr (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .async_i(clear_strobe_n_i),
      .level_o(), .fall_o(clr_fall), .rise_o());

   // ------------------------------------------------------------
   // frame receiver
   // ------------------------------------------------------------
   qdu_frame_state_t state_reg;
   qdu_frame_state_t state_next;
   logic [FRAME_BITS-1:0] shift_reg;
   logic [FRAME_BITS-1:0] shift_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic done_reg;
   logic done_next;
   logic [FRAME_BITS-1:0] word;

   // each edge seen in one sampled cycle; the 32nd edge completes the word
   assign word = {shift_reg[FRAME_BITS-2:0], din_lvl};

   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      done_next = 1'b0;
      case (state_reg)
         FR_IDLE: begin
            if (fs_fall && !clr_fall) begin
               cnt_next = '0;
               shift_next = '0;
               state_next = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (clr_fall || fs_rise || fs_lvl) begin
               // aborted: shift contents dropped, nothing applied
               shift_next = '0;
               cnt_next = '0;
               state_next = FR_IDLE;
            end else if (sclk_fall) begin
               shift_next = word;
               if (cnt_reg == CNT_W'(FRAME_BITS - 1)) begin
                  done_next = 1'b1;
                  state_next = FR_WAIT_END;
               end else begin
                  cnt_next = cnt_reg + CNT_W'(1);
               end
            end
         end
         FR_WAIT_END: begin
            // extra edges past the 32nd are ignored until frame select rises
            if (fs_lvl) begin
               state_next = FR_IDLE;
            end
         end
         default: state_next = FR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= FR_IDLE;
         shift_reg <= '0;
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   // ------------------------------------------------------------
   // command decode and register update
   // ------------------------------------------------------------
   logic [3:0] command_field;
   logic [3:0] channel_address_field;
   logic [CODE_W-1:0] data_field;
   logic [CODE_W-1:0] clear_value;
   assign command_field = shift_reg[CMD_MSB:CMD_LSB];
   assign channel_address_field = shift_reg[ADDR_MSB:ADDR_LSB];
   assign data_field = shift_reg[DATA_MSB:DATA_LSB];

   logic [CHANNELS-1:0] override_reg;
   logic [CHANNELS-1:0] override_next;
   logic [1:0] clear_sel_reg;
   logic [1:0] clear_sel_next;

   always_comb begin
      case (clear_sel_reg)
         CLR_SEL_ZERO: clear_value = CLR_CODE_ZERO;
         CLR_SEL_MID: clear_value = CLR_CODE_MID;
         CLR_SEL_FULL: clear_value = CLR_CODE_FULL;
         default: clear_value = CLR_CODE_ZERO;
      endcase
   end

   always_comb begin
      override_next = override_reg;
      clear_sel_next = clear_sel_reg;
      if (done_reg && command_field == CMD_LOAD_OVERRIDE) begin
         override_next = shift_reg[CHANNELS-1:0];
      end
      if (done_reg && command_field == CMD_LOAD_CLEAR_SEL) begin
         clear_sel_next = shift_reg[1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         override_reg <= OVERRIDE_RESET;
         clear_sel_reg <= CLR_SEL_RESET;
      end else begin
         override_reg <= override_next;
         clear_sel_reg <= clear_sel_next;
      end
   end

   logic [CODE_W-1:0] in_reg [CHANNELS];
   logic [CODE_W-1:0] dac_reg [CHANNELS];
   logic do_clear;
   logic wr_data;
   // a no-clear selector leaves the registers alone; the pin edge still aborts a frame
   assign do_clear = clr_fall && (clear_sel_reg != CLR_SEL_NONE);
   assign wr_data = done_reg && (command_field == CMD_WRITE_INPUT ||
                                 command_field == CMD_WRITE_UPDATE_ALL ||
                                 command_field == CMD_WRITE_UPDATE_ONE);

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         logic [CODE_W-1:0] in_next;
         logic [CODE_W-1:0] dac_next;
         logic hit;
         logic pin_low;
         assign hit = (channel_address_field == ADDR_ALL) ||
                      (channel_address_field == 4'(g));
         // override bit makes the channel see the strobe as tied low
         assign pin_low = override_reg[g] | ~ld_lvl;
         always_comb begin
            in_next = in_reg[g];
            dac_next = dac_reg[g];
            if (do_clear) begin
               in_next = clear_value;
               dac_next = clear_value;
            end else begin
               if (wr_data && hit) begin
                  in_next = data_field;
               end
               if (wr_data && command_field == CMD_WRITE_UPDATE_ALL) begin
                  // all channels update, the new word included
                  dac_next = in_next;
               end else if (wr_data && hit && pin_low) begin
                  dac_next = in_next;
               end else if (wr_data && hit && command_field == CMD_WRITE_UPDATE_ONE) begin
                  dac_next = in_next;
               end else if (ld_fall && !override_reg[g]) begin
                  dac_next = in_reg[g];
               end
            end
         end
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               in_reg[g] <= DAC_RESET;
               dac_reg[g] <= DAC_RESET;
            end else begin
               in_reg[g] <= in_next;
               dac_reg[g] <= dac_next;
            end
         end
         assign input_regs_o[g*CODE_W +: CODE_W] = in_reg[g];
         assign dac_regs_o[g*CODE_W +: CODE_W] = dac_reg[g];
      end
   endgenerate

   assign override_o = override_reg;
   assign clear_sel_o = clear_sel_reg;
   assign frame_done_o = done_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_override_frame;
      done_reg && command_field == CMD_LOAD_OVERRIDE;
   endsequence

   override_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      s_override_frame |=> override_reg == $past(shift_reg[CHANNELS-1:0]))
      else $error("override register not loaded from frame");

   clear_sel_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      done_reg && command_field == CMD_LOAD_CLEAR_SEL |=> clear_sel_reg == $past(shift_reg[1:0]))
      else $error("clear selector not loaded");

   clear_value_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      do_clear && clear_sel_reg == CLR_SEL_MID |=> dac_reg[0] == CLR_CODE_MID && in_reg[3] == CLR_CODE_MID)
      else $error("clear code not applied");

   clear_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      clr_fall && state_reg == FR_SHIFT |=> state_reg == FR_IDLE && !done_reg)
      else $error("frame not aborted by clear");

   early_end_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      state_reg == FR_SHIFT && fs_rise |=> !done_reg ##1 !done_reg)
      else $error("aborted frame completed");

   frame_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      done_next |-> cnt_reg == CNT_W'(FRAME_BITS - 1) && sclk_fall)
      else $error("frame completed at wrong edge count");

   update_all_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_data && command_field == CMD_WRITE_UPDATE_ALL && !do_clear |=> dac_reg[2] == in_reg[2])
      else $error("update all missed a channel");

   async_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      wr_data && command_field == CMD_WRITE_INPUT && !override_reg[1] && ld_lvl && !ld_fall && !do_clear
      |=> dac_reg[1] == $past(dac_reg[1]))
      else $error("dac register changed during asynchronous write");

   strobe_update_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ld_fall && !override_reg[0] && !do_clear && !wr_data |=> dac_reg[0] == $past(in_reg[0]))
      else $error("strobe edge did not update channel");

   sequence s_sync_write_a0;
      wr_data && command_field == CMD_WRITE_INPUT && channel_address_field == 4'h0 &&
      !ld_lvl && !do_clear;
   endsequence

   sequence s_override_write_b;
      wr_data && command_field == CMD_WRITE_INPUT && channel_address_field == 4'h1 &&
      override_reg[1] && !do_clear;
   endsequence

   pin_sync_update_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      s_sync_write_a0 |=> dac_reg[0] == $past(data_field))
      else $error("strobe low did not update channel at frame end");

   override_sync_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      s_override_write_b |=> dac_reg[1] == $past(data_field))
      else $error("override channel not updated at frame end");

   override_skip_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ld_fall && override_reg[3] && !wr_data && !do_clear |=> dac_reg[3] == $past(dac_reg[3]))
      else $error("override channel followed the strobe edge");

   reset_values_a: assert property (@(posedge ref_clk_i)
      $rose(rst_b_i) |-> override_reg == OVERRIDE_RESET && clear_sel_reg == CLR_SEL_RESET)
      else $error("registers not at reset values");

   shift_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      state_reg == FR_SHIFT && sclk_fall && !clr_fall && !fs_lvl |=> shift_reg[0] == $past(din_lvl))
      else $error("serial bit not shifted in");

   frame_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      state_reg == FR_IDLE && fs_fall && !clr_fall |=> state_reg == FR_SHIFT && cnt_reg == '0)
      else $error("frame did not start");

   done_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      done_reg |=> !done_reg)
      else $error("frame done held longer than one cycle");

   cut_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      state_reg == FR_SHIFT && (fs_lvl || clr_fall) |=> state_reg == FR_IDLE && shift_reg == '0)
      else $error("cut frame left shift contents");

   no_clear_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      clr_fall && clear_sel_reg == CLR_SEL_NONE && !wr_data && !ld_fall
      |=> in_reg[3] == $past(in_reg[3]) && dac_reg[3] == $past(dac_reg[3]))
      else $error("no-clear selector changed a register");
endmodule

// ===== qdu_host_model.sv
// host serial controller model driving clock, frame select and data
`timescale 1ns/1ps
module qdu_host_model (
   input wire logic ref_clk_i,
   output logic sclk_o,
   output logic frame_sel_n_o,
   output logic sdin_o
);
   // serial clock stands high between frames
   initial begin
      sclk_o = 1'b1;
      frame_sel_n_o = 1'b1;
      sdin_o = 1'b0;
   end

   // half of an 80 ns serial clock period
   task automatic half();
      repeat (4) @(negedge ref_clk_i);
   endtask

   // fewer than 32 edges makes a cut-short frame
   task automatic send_frame(input logic [31:0] word, input int n_edges);
      frame_sel_n_o = 1'b0;
      half();
      for (int i = 31; i > 31 - n_edges; i--) begin
         sdin_o = word[i];
         half();
         sclk_o = 1'b0;
         half();
         sclk_o = 1'b1;
      end
      half();
      frame_sel_n_o = 1'b1;
      // released line shows no stale bit
      sdin_o = ~sdin_o;
      half();
      half();
   endtask
endmodule

// ===== qdu_top_tb_top.sv
// self-checking testbench for the quad dac update and clear control block
`timescale 1ns/1ps
module qdu_top_tb_top;
   import qdu_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic load_strobe_n_i = 1'b1;
   logic clear_strobe_n_i = 1'b1;
   logic sclk;
   logic frame_sel_n;
   logic sdin;
   logic [63:0] input_regs;
   logic [63:0] dac_regs;
   logic [63:0] exp_in = '0;
   logic [63:0] exp_dac = '0;
   logic [3:0] override;
   logic [1:0] clear_sel;
   logic frame_done;
   int fail_count = 0;
   int n_tests = 0;
   int done_count = 0;

   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   qdu_host_model host_u (
      .ref_clk_i(ref_clk_i),
      .sclk_o(sclk),
      .frame_sel_n_o(frame_sel_n),
      .sdin_o(sdin)
   );

   qdu_top dut_u (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .sclk_i(sclk),
      .frame_sel_n_i(frame_sel_n),
      .sdin_i(sdin),
      .load_strobe_n_i(load_strobe_n_i),
      .clear_strobe_n_i(clear_strobe_n_i),
      .input_regs_o(input_regs),
      .dac_regs_o(dac_regs),
      .override_o(override),
      .clear_sel_o(clear_sel),
      .frame_done_o(frame_done)
   );

   // sampled off the launching edge so the pulse is settled
   always @(negedge ref_clk_i) begin
      if (frame_done === 1'b1) begin
         done_count++;
      end
   end

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] mk(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d,
                                      input logic [3:0] lo);
      return {4'hA, c, a, d, lo};
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] w);
      host_u.send_frame(w, 32);
   endtask

   task automatic pulse(input bit clr);
      @(negedge ref_clk_i);
      if (clr) begin
         clear_strobe_n_i = 1'b0;
      end else begin
         load_strobe_n_i = 1'b0;
      end
      repeat (8) @(negedge ref_clk_i);
      clear_strobe_n_i = 1'b1;
      load_strobe_n_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_sync();
      chk({60'h0, override}, {60'h0, OVERRIDE_RESET});
      // strobe held low for end-of-frame updates
      load_strobe_n_i = 1'b0;
      wr(mk(CMD_WRITE_INPUT, 4'h0, 16'h1234, 4'h5));
      exp_in[15:0] = 16'h1234;
      exp_dac[15:0] = 16'h1234;
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      chk(64'(done_count), 64'h1);
   endtask

   task automatic t_async();
      @(negedge ref_clk_i);
      load_strobe_n_i = 1'b1;
      wr(mk(CMD_WRITE_INPUT, 4'h1, 16'hABCD, 4'h5));
      exp_in[31:16] = 16'hABCD;
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      pulse(1'b0);
      exp_dac = exp_in;
      chk(dac_regs, exp_dac);
      wr(mk(CMD_WRITE_UPDATE_ALL, 4'h2, 16'h5555, 4'h5));
      exp_in[47:32] = 16'h5555;
      exp_dac = exp_in;
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      // addressed write and update leaves the other channels alone
      wr(mk(CMD_WRITE_UPDATE_ONE, 4'h3, 16'h6666, 4'h5));
      exp_in[63:48] = 16'h6666;
      exp_dac[63:48] = 16'h6666;
      chk(dac_regs, exp_dac);
      wr(mk(CMD_WRITE_INPUT, ADDR_ALL, 16'h4321, 4'h5));
      exp_in = {4{16'h4321}};
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
   endtask

   task automatic t_override();
      // channel d gets a stale dac code before the mask is set
      wr(mk(CMD_WRITE_INPUT, 4'h3, 16'h3333, 4'h5));
      exp_in[63:48] = 16'h3333;
      chk(dac_regs, exp_dac);
      // junk address and data must not leak into the mask
      wr(mk(CMD_LOAD_OVERRIDE, 4'h3, 16'hFFFF, 4'hA));
      chk({60'h0, override}, 64'hA);
      wr(mk(CMD_WRITE_INPUT, 4'h1, 16'h1111, 4'h5));
      exp_in[31:16] = 16'h1111;
      exp_dac[31:16] = 16'h1111;
      chk(dac_regs, exp_dac);
      wr(mk(CMD_WRITE_INPUT, 4'h0, 16'h2222, 4'h5));
      exp_in[15:0] = 16'h2222;
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      pulse(1'b0);
      // overridden channel d ignores the strobe edge
      exp_dac = {exp_dac[63:48], exp_in[47:0]};
      chk(dac_regs, exp_dac);
   endtask

   task automatic t_clear();
      logic [1:0] sels [4];
      logic [15:0] codes [4];
      sels = '{2'h3, 2'h1, 2'h2, 2'h0};
      codes = '{16'h0000, 16'h8000, 16'hFFFF, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         wr(mk(CMD_LOAD_CLEAR_SEL, 4'hF, 16'hFFFF, {2'h2, sels[i]}));
         chk({62'h0, clear_sel}, {62'h0, sels[i]});
         pulse(1'b1);
         if (sels[i] != 2'h3) begin
            exp_in = {4{codes[sels[i]]}};
            exp_dac = exp_in;
         end
         chk(input_regs, exp_in);
         chk(dac_regs, exp_dac);
      end
   endtask

   task automatic t_abort();
      int n;
      n = done_count;
      host_u.send_frame(mk(CMD_WRITE_UPDATE_ALL, 4'h3, 16'h7777, 4'h5), 31);
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      chk(64'(done_count), 64'(n));
      fork
         wr(mk(CMD_WRITE_UPDATE_ALL, 4'h3, 16'h7777, 4'h5));
         begin
            repeat (100) @(negedge ref_clk_i);
            pulse(1'b1);
         end
      join
      chk(input_regs, exp_in);
      chk(dac_regs, exp_dac);
      chk(64'(done_count), 64'(n));
   endtask

   // ---------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------
   initial begin
      repeat (12) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      t_sync();
      t_async();
      t_override();
      t_clear();
      t_abort();
      end_of_test();
   end

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      fail_count++;
      end_of_test();
   end
endmodule
